// *** rtl/chan_table_pkg.sv ***
package chan_table_pkg;
   localparam int VCI_W = 20;
   localparam int CF_W = 2;
   localparam int MAP_W = 16;
   localparam int CL_ENTRIES = 8;
   localparam int IDX_W = 3;
   localparam int EP_COUNT = 4;
   localparam int EP_W = 2;
   localparam int PAIRS = 4;
   localparam int PAIR_W = 2;
   localparam int OFS_W = 6;
   localparam int MID_PAGES = 4;
   localparam int MID_W = 2;
   localparam int SEQ_W = 4;
   localparam int REASON_W = 3;
   localparam int PRIO_W = 2;
   localparam logic [OFS_W-1:0] OFS_MIN = 6'h01;
   localparam logic [OFS_W-1:0] OFS_MAX = 6'h30;
   localparam logic [PRIO_W-1:0] PRIO_MAX = 2'h2;
   localparam logic [CF_W-1:0] CF_MAC = 2'h0;
   localparam logic [SEQ_W-1:0] SEQ_RESET = 4'h0;
   localparam logic [REASON_W-1:0] RSN_NONE = 3'h0;
   localparam logic [REASON_W-1:0] RSN_REBIND = 3'h1;
   localparam logic [REASON_W-1:0] RSN_FULL = 3'h2;
   localparam logic [REASON_W-1:0] RSN_NOT_FOUND = 3'h3;
   localparam logic [REASON_W-1:0] RSN_BAD_OFFSET = 3'h4;
   localparam logic [REASON_W-1:0] RSN_BAD_CMD = 3'h5;
   localparam logic [REASON_W-1:0] RSN_MAP_CLASH = 3'h6;
   typedef enum logic [1:0] {
      CMD_CHANNEL_ADD,
      CMD_CHANNEL_REMOVE,
      CMD_ENDPOINT_OPEN,
      CMD_OTHER
   } cmd_t;
   typedef enum logic {DIR_TRANSMIT, DIR_RECEIVE} dir_t;
   typedef enum logic {BUS_SEL_A, BUS_SEL_B} bus_t;
endpackage

// *** rtl/channel_id_table_manager.sv ***
// Overview of operation
// RULE_01: connectionless add implies both buses for transmit and receive, no bus given.
// RULE_02: connectionless traffic may use any access priority zero to two.
// RULE_03: channels may be shared; a direction is usable only after its add.
// RULE_04: add enables the channel and binds it to the named adaptation type.
// RULE_05: each add names transmit or receive; only that direction is recorded.
// RULE_06: mapping criteria are kept and matched for transmit entries only.
// RULE_07: add for mac adaptation clears sequence counters for all message pages; the code clears them only on a transmit add.
// RULE_08: every add, remove or open returns exactly one reply with status.
// RULE_09: management binds one channel to only one adaptation function.
// RULE_10: both directions need two separate actions from management.
// RULE_11: transmit channels of one function need distinct mapping criteria.
// RULE_12: several receive channels per function accepted without uniqueness check.
// RULE_13: remove unbinds the channel and stops traffic in that direction.
// RULE_14: new mapping criteria need remove then add by management.
// RULE_15: one isochronous endpoint per isochronous user, possibly null conversion.
// RULE_16: open records transmit bus with pairs and receive bus with pairs.
// RULE_17: octet offsets name payload position and lie in one to forty-eight.
// RULE_18: transmit and receive bus fields are bus a or bus b.
// RULE_19: open links endpoint to bus and pairs, then enables data flow.
// RULE_20: connectionless functions addressed by type, endpoints by identifier.
// RULE_21: reply status successful or unsuccessful, failure carries a reason code.
// RULE_22: bad offset or rebinding add gets failure reply and no table change.
`timescale 1ns/1ns
module channel_id_table_manager #(
   parameter int ENTRIES = chan_table_pkg::CL_ENTRIES,
   parameter int ENDPOINTS = chan_table_pkg::EP_COUNT
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_cmd_valid,
   input wire chan_table_pkg::cmd_t i_cmd,
   input wire logic [chan_table_pkg::CF_W-1:0] i_cf_type,
   input wire logic [chan_table_pkg::VCI_W-1:0] i_vci,
   input wire chan_table_pkg::dir_t i_dir,
   input wire logic [chan_table_pkg::MAP_W-1:0] i_map,
   input wire logic [chan_table_pkg::EP_W-1:0] i_endpoint_identifier,
   input wire chan_table_pkg::bus_t i_tx_bus,
   input wire chan_table_pkg::bus_t i_rx_bus,
   input wire logic [chan_table_pkg::PAIRS*chan_table_pkg::VCI_W-1:0] i_tx_vcis,
   input wire logic [chan_table_pkg::PAIRS*chan_table_pkg::OFS_W-1:0] i_tx_ofs,
   input wire logic [chan_table_pkg::PAIRS-1:0] i_tx_used,
   input wire logic [chan_table_pkg::PAIRS*chan_table_pkg::VCI_W-1:0] i_rx_vcis,
   input wire logic [chan_table_pkg::PAIRS*chan_table_pkg::OFS_W-1:0] i_rx_ofs,
   input wire logic [chan_table_pkg::PAIRS-1:0] i_rx_used,
   output logic o_reply_valid,
   output logic o_reply_ok,
   output logic [chan_table_pkg::REASON_W-1:0] o_reply_reason,
   input wire logic [chan_table_pkg::CF_W-1:0] i_sel_cf,
   input wire logic [chan_table_pkg::MAP_W-1:0] i_sel_map,
   input wire logic [chan_table_pkg::PRIO_W-1:0] i_sel_prio,
   output logic o_sel_hit,
   output logic [chan_table_pkg::VCI_W-1:0] o_sel_vci,
   output logic o_sel_bus_a,
   output logic o_sel_bus_b,
   input wire logic [chan_table_pkg::VCI_W-1:0] i_rx_chk_vci,
   input wire logic [chan_table_pkg::CF_W-1:0] i_rx_chk_cf,
   output logic o_rx_accept,
   input wire logic i_seq_step,
   input wire logic [chan_table_pkg::MID_W-1:0] i_seq_mid,
   output logic [chan_table_pkg::SEQ_W-1:0] o_seq,
   input wire logic [chan_table_pkg::EP_W-1:0] i_ep_query,
   input wire logic [chan_table_pkg::PAIR_W-1:0] i_pair_query,
   output logic o_ep_active,
   output logic o_ep_tx_bus_b,
   output logic o_ep_rx_bus_b,
   output logic [chan_table_pkg::VCI_W-1:0] o_ep_tx_vci,
   output logic [chan_table_pkg::OFS_W-1:0] o_ep_tx_ofs,
   output logic o_ep_tx_pair_used,
   output logic [chan_table_pkg::VCI_W-1:0] o_ep_rx_vci,
   output logic [chan_table_pkg::OFS_W-1:0] o_ep_rx_ofs,
   output logic o_ep_rx_pair_used
);
   import chan_table_pkg::*;

   // connectionless channel table, one entry per enabled channel direction
   logic [ENTRIES-1:0] cl_valid_reg;
   logic [VCI_W-1:0] cl_vci_reg [ENTRIES];
   logic [CF_W-1:0] cl_cf_reg [ENTRIES];
   dir_t cl_dir_reg [ENTRIES];
   logic [MAP_W-1:0] cl_map_reg [ENTRIES];
   // isochronous endpoint table, one endpoint per isochronous user
   logic [ENDPOINTS-1:0] ep_active_reg;
   bus_t ep_tx_bus_reg [ENDPOINTS];
   bus_t ep_rx_bus_reg [ENDPOINTS];
   logic [PAIRS*VCI_W-1:0] ep_tx_vci_reg [ENDPOINTS];
   logic [PAIRS*OFS_W-1:0] ep_tx_ofs_reg [ENDPOINTS];
   logic [PAIRS-1:0] ep_tx_used_reg [ENDPOINTS];
   logic [PAIRS*VCI_W-1:0] ep_rx_vci_reg [ENDPOINTS];
   logic [PAIRS*OFS_W-1:0] ep_rx_ofs_reg [ENDPOINTS];
   logic [PAIRS-1:0] ep_rx_used_reg [ENDPOINTS];

   function automatic logic offsets_ok(input logic [PAIRS*OFS_W-1:0] ofs,
                                       input logic [PAIRS-1:0] used);
      logic ok;
      logic [OFS_W-1:0] o;
      ok = 1'b1;
      for (int p = 0; p < PAIRS; p++) begin
         o = ofs[p*OFS_W +: OFS_W];
         if (used[p] && (o < OFS_MIN || o > OFS_MAX)) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction

   // lookup of command against table
   logic match_same, bound_other, map_clash, have_free;
   logic [IDX_W-1:0] match_idx, free_idx;
   always_comb begin
      match_same = 1'b0;
      bound_other = 1'b0;
      map_clash = 1'b0;
      have_free = 1'b0;
      match_idx = '0;
      free_idx = '0;
      for (int e = ENTRIES - 1; e >= 0; e--) begin
         if (!cl_valid_reg[e]) begin
            have_free = 1'b1;
            free_idx = IDX_W'(e);
         end else begin
            if (cl_vci_reg[e] == i_vci && cl_dir_reg[e] == i_dir) begin
               match_same = 1'b1;
               match_idx = IDX_W'(e);
            end
            if (cl_vci_reg[e] == i_vci && cl_cf_reg[e] != i_cf_type) begin
               bound_other = 1'b1;
            end
            // receive entries never clash
            if (i_dir == DIR_TRANSMIT && cl_dir_reg[e] == DIR_TRANSMIT &&
                cl_cf_reg[e] == i_cf_type && cl_map_reg[e] == i_map) begin
               map_clash = 1'b1; // [RULE_11] [RULE_12]
            end
         end
      end
   end

   // decide outcome of the current action
   logic act_ok, do_add, do_remove, do_open;
   logic [REASON_W-1:0] act_reason;
   always_comb begin
      act_ok = 1'b0;
      act_reason = RSN_BAD_CMD;
      case (i_cmd)
         CMD_CHANNEL_ADD: begin
            if (bound_other || match_same) begin
               act_reason = RSN_REBIND; // [RULE_22]
            end else if (map_clash) begin
               act_reason = RSN_MAP_CLASH; // [RULE_11]
            end else if (!have_free) begin
               act_reason = RSN_FULL;
            end else begin
               act_ok = 1'b1;
               act_reason = RSN_NONE;
            end
         end
         CMD_CHANNEL_REMOVE: begin
            if (match_same) begin
               act_ok = 1'b1;
               act_reason = RSN_NONE;
            end else begin
               act_reason = RSN_NOT_FOUND;
            end
         end
         CMD_ENDPOINT_OPEN: begin
            if (offsets_ok(i_tx_ofs, i_tx_used) && offsets_ok(i_rx_ofs, i_rx_used)) begin
               act_ok = 1'b1; // [RULE_17]
               act_reason = RSN_NONE;
            end else begin
               act_reason = RSN_BAD_OFFSET; // [RULE_22]
            end
         end
         default: begin
            act_ok = 1'b0;
            act_reason = RSN_BAD_CMD;
         end
      endcase
      do_add = i_cmd_valid && act_ok && i_cmd == CMD_CHANNEL_ADD;
      do_remove = i_cmd_valid && act_ok && i_cmd == CMD_CHANNEL_REMOVE;
      do_open = i_cmd_valid && act_ok && i_cmd == CMD_ENDPOINT_OPEN;
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cl_valid_reg <= '0;
      end else if (do_add) begin
         cl_valid_reg[free_idx] <= 1'b1; // [RULE_04] [RULE_03]
      end else if (do_remove) begin
         cl_valid_reg[match_idx] <= 1'b0; // [RULE_13]
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int e = 0; e < ENTRIES; e++) begin
            cl_vci_reg[e] <= '0;
            cl_cf_reg[e] <= '0;
            cl_dir_reg[e] <= DIR_TRANSMIT;
            cl_map_reg[e] <= '0;
         end
      end else if (do_add) begin
         cl_vci_reg[free_idx] <= i_vci;
         cl_cf_reg[free_idx] <= i_cf_type; // [RULE_04] [RULE_20]
         cl_dir_reg[free_idx] <= i_dir; // [RULE_05]
         cl_map_reg[free_idx] <= (i_dir == DIR_TRANSMIT) ? i_map : '0; // [RULE_06]
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ep_active_reg <= '0;
         for (int k = 0; k < ENDPOINTS; k++) begin
            ep_tx_bus_reg[k] <= BUS_SEL_A;
            ep_rx_bus_reg[k] <= BUS_SEL_A;
            ep_tx_vci_reg[k] <= '0;
            ep_tx_ofs_reg[k] <= '0;
            ep_tx_used_reg[k] <= '0;
            ep_rx_vci_reg[k] <= '0;
            ep_rx_ofs_reg[k] <= '0;
            ep_rx_used_reg[k] <= '0;
         end
      end else if (do_open) begin
         ep_tx_bus_reg[i_endpoint_identifier] <= i_tx_bus; // [RULE_16] [RULE_18]
         ep_rx_bus_reg[i_endpoint_identifier] <= i_rx_bus; // [RULE_18]
         ep_tx_vci_reg[i_endpoint_identifier] <= i_tx_vcis; // [RULE_16]
         ep_tx_ofs_reg[i_endpoint_identifier] <= i_tx_ofs;
         ep_tx_used_reg[i_endpoint_identifier] <= i_tx_used;
         ep_rx_vci_reg[i_endpoint_identifier] <= i_rx_vcis;
         ep_rx_ofs_reg[i_endpoint_identifier] <= i_rx_ofs;
         ep_rx_used_reg[i_endpoint_identifier] <= i_rx_used;
         ep_active_reg[i_endpoint_identifier] <= 1'b1; // [RULE_19] [RULE_15]
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_reply_valid <= 1'b0;
         o_reply_ok <= 1'b0;
         o_reply_reason <= RSN_NONE;
      end else begin
         o_reply_valid <= i_cmd_valid; // [RULE_08]
         if (i_cmd_valid) begin
            o_reply_ok <= act_ok; // [RULE_21]
            o_reply_reason <= act_reason;
         end
      end
   end

   // transmit channel selection by mapping criteria, both buses usable
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_sel_hit <= 1'b0;
         o_sel_vci <= '0;
      end else begin
         o_sel_hit <= 1'b0;
         o_sel_vci <= '0;
         for (int e = 0; e < ENTRIES; e++) begin
            if (cl_valid_reg[e] && cl_dir_reg[e] == DIR_TRANSMIT && cl_cf_reg[e] == i_sel_cf &&
                cl_map_reg[e] == i_sel_map && i_sel_prio <= PRIO_MAX) begin
               o_sel_hit <= 1'b1; // [RULE_06] [RULE_02] [RULE_03]
               o_sel_vci <= cl_vci_reg[e];
            end
         end
      end
   end
   assign o_sel_bus_a = o_sel_hit; // [RULE_01]
   assign o_sel_bus_b = o_sel_hit; // [RULE_01]

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rx_accept <= 1'b0;
      end else begin
         o_rx_accept <= 1'b0;
         for (int e = 0; e < ENTRIES; e++) begin
            if (cl_valid_reg[e] && cl_dir_reg[e] == DIR_RECEIVE &&
                cl_vci_reg[e] == i_rx_chk_vci && cl_cf_reg[e] == i_rx_chk_cf) begin
               o_rx_accept <= 1'b1; // [RULE_03] [RULE_12]
            end
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_ep_active <= 1'b0;
         o_ep_tx_bus_b <= 1'b0;
         o_ep_rx_bus_b <= 1'b0;
         o_ep_tx_vci <= '0;
         o_ep_tx_ofs <= '0;
         o_ep_tx_pair_used <= 1'b0;
         o_ep_rx_vci <= '0;
         o_ep_rx_ofs <= '0;
         o_ep_rx_pair_used <= 1'b0;
      end else begin
         o_ep_active <= ep_active_reg[i_ep_query];
         o_ep_tx_bus_b <= ep_tx_bus_reg[i_ep_query] == BUS_SEL_B;
         o_ep_rx_bus_b <= ep_rx_bus_reg[i_ep_query] == BUS_SEL_B;
         o_ep_tx_vci <= ep_tx_vci_reg[i_ep_query][i_pair_query*VCI_W +: VCI_W];
         o_ep_tx_ofs <= ep_tx_ofs_reg[i_ep_query][i_pair_query*OFS_W +: OFS_W];
         o_ep_tx_pair_used <= ep_tx_used_reg[i_ep_query][i_pair_query];
         o_ep_rx_vci <= ep_rx_vci_reg[i_ep_query][i_pair_query*VCI_W +: VCI_W];
         o_ep_rx_ofs <= ep_rx_ofs_reg[i_ep_query][i_pair_query*OFS_W +: OFS_W];
         o_ep_rx_pair_used <= ep_rx_used_reg[i_ep_query][i_pair_query];
      end
   end

   // sequence counters follow the looked-up transmit channel
   logic [IDX_W-1:0] step_idx;
   always_comb begin
      step_idx = '0;
      for (int e = 0; e < ENTRIES; e++) begin
         if (cl_valid_reg[e] && cl_dir_reg[e] == DIR_TRANSMIT && cl_cf_reg[e] == i_sel_cf &&
             cl_map_reg[e] == i_sel_map) begin
            step_idx = IDX_W'(e);
         end
      end
   end

   seq_counter_bank #(.ENTRIES(ENTRIES), .PAGES(MID_PAGES)) u_seq (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_clear(do_add && i_cf_type == CF_MAC && i_dir == DIR_TRANSMIT), // [RULE_07]
      .i_clear_idx(free_idx),
      .i_step(i_seq_step),
      .i_step_idx(step_idx),
      .i_step_mid(i_seq_mid),
      .o_seq(o_seq)
   );

   sequence s_cmd_in;
      i_cmd_valid;
   endsequence
   sequence s_reply_out;
      o_reply_valid;
   endsequence

   chk_reply_per_action: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      s_cmd_in |=> s_reply_out) // [RULE_08]
      else $error("action without reply");
   chk_no_spurious_reply: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      !i_cmd_valid |=> !o_reply_valid) // [RULE_08]
      else $error("reply without action");
   chk_fail_reason: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      o_reply_valid |-> (o_reply_ok == (o_reply_reason == RSN_NONE))) // [RULE_21]
      else $error("reason code inconsistent with status");
   chk_bad_offset_rejected: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_cmd_valid && i_cmd == CMD_ENDPOINT_OPEN && !offsets_ok(i_tx_ofs, i_tx_used)
      |=> !o_reply_ok && o_reply_reason == RSN_BAD_OFFSET) // [RULE_22]
      else $error("bad offset accepted");
   chk_rebind_no_change: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_cmd_valid && i_cmd == CMD_CHANNEL_ADD && bound_other
      |=> cl_valid_reg == $past(cl_valid_reg) && !o_reply_ok) // [RULE_22]
      else $error("rebinding add changed table");
   chk_add_records: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE_05]
      do_add |=> cl_valid_reg[$past(free_idx)] && cl_dir_reg[$past(free_idx)] == $past(i_dir))
      else $error("add did not record entry");
   chk_remove_stops: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      do_remove |=> !cl_valid_reg[$past(match_idx)]) // [RULE_13]
      else $error("remove left entry enabled");
   chk_open_enables: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      do_open |=> ep_active_reg[$past(i_endpoint_identifier)] &&
      ep_tx_bus_reg[$past(i_endpoint_identifier)] == $past(i_tx_bus)) // [RULE_19]
      else $error("open did not enable endpoint");
   chk_both_buses: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      o_sel_hit |-> o_sel_bus_a && o_sel_bus_b) // [RULE_01]
      else $error("selected channel not on both buses");
endmodule

// *** rtl/seq_counter_bank.sv ***
`timescale 1ns/1ns
module seq_counter_bank #(
   parameter int ENTRIES = chan_table_pkg::CL_ENTRIES,
   parameter int PAGES = chan_table_pkg::MID_PAGES
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_clear,
   input wire logic [chan_table_pkg::IDX_W-1:0] i_clear_idx,
   input wire logic i_step,
   input wire logic [chan_table_pkg::IDX_W-1:0] i_step_idx,
   input wire logic [chan_table_pkg::MID_W-1:0] i_step_mid,
   output logic [chan_table_pkg::SEQ_W-1:0] o_seq
);
   import chan_table_pkg::*;
   logic [SEQ_W-1:0] seq_reg [ENTRIES][PAGES];

   // clear covers every message page of a channel at once
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int e = 0; e < ENTRIES; e++) begin
            for (int p = 0; p < PAGES; p++) begin
               seq_reg[e][p] <= SEQ_RESET;
            end
         end
      end else begin
         for (int e = 0; e < ENTRIES; e++) begin
            for (int p = 0; p < PAGES; p++) begin
               if (i_clear && i_clear_idx == IDX_W'(e)) begin
                  seq_reg[e][p] <= SEQ_RESET; // [RULE_07]
               end else if (i_step && i_step_idx == IDX_W'(e) && i_step_mid == MID_W'(p)) begin
                  seq_reg[e][p] <= seq_reg[e][p] + 1'b1;
               end
            end
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_seq <= SEQ_RESET;
      end else begin
         o_seq <= seq_reg[i_step_idx][i_step_mid];
      end
   end

   chk_clear_zeroes: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_clear |=> seq_reg[$past(i_clear_idx)][0] == SEQ_RESET) // [RULE_07]
      else $error("sequence counter not cleared");
endmodule

// *** verification/mgmt_process_model.sv ***
`timescale 1ns/1ns
module mgmt_process_model (
   input wire logic i_core_clk,
   input wire logic i_reply_valid,
   output logic o_cmd_valid,
   output chan_table_pkg::cmd_t o_cmd,
   output logic [chan_table_pkg::CF_W-1:0] o_cf_type,
   output logic [chan_table_pkg::VCI_W-1:0] o_vci,
   output chan_table_pkg::dir_t o_dir,
   output logic [chan_table_pkg::MAP_W-1:0] o_map,
   output logic [chan_table_pkg::EP_W-1:0] o_endpoint_identifier
);
   import chan_table_pkg::*;
   initial begin
      o_cmd_valid = 1'b0;
      o_cmd = CMD_OTHER;
      o_cf_type = 2'h0;
      o_vci = 20'h0;
      o_dir = DIR_TRANSMIT;
      o_map = 16'h0;
      o_endpoint_identifier = 2'h0;
   end
   // one pulse per action, one direction per action
   // callers keep each channel on one adaptation type, bar the rebind probe
   task automatic issue(input cmd_t c, input logic [CF_W-1:0] f, input logic [VCI_W-1:0] v,
         input dir_t d, input logic [MAP_W-1:0] m, input logic [EP_W-1:0] e, output logic seen);
      @(negedge i_core_clk);
      o_cmd_valid = 1'b1;
      o_cmd = c;
      o_cf_type = f; // adaptation named by type
      o_vci = v;
      o_dir = d;
      o_map = m;
      o_endpoint_identifier = e; // endpoint named by identifier
      @(negedge i_core_clk);
      o_cmd_valid = 1'b0;
      o_vci = ~v;
      o_map = ~m;
      seen = i_reply_valid;
   endtask
endmodule

// *** verification/testbench.sv ***
`timescale 1ns/1ns
module testbench;
   import chan_table_pkg::*;
   logic i_core_clk = 1'b0, i_rst_n = 1'b0, i_seq_step = 1'b0, seen;
   logic i_cmd_valid, o_reply_valid, o_reply_ok, o_sel_hit, o_sel_bus_a, o_sel_bus_b;
   logic o_rx_accept, o_ep_active, o_ep_tx_bus_b, o_ep_rx_bus_b;
   logic o_ep_tx_pair_used, o_ep_rx_pair_used;
   cmd_t i_cmd;
   dir_t i_dir;
   bus_t i_tx_bus = BUS_SEL_A, i_rx_bus = BUS_SEL_A;
   logic [CF_W-1:0] i_cf_type, i_sel_cf = 2'h0, i_rx_chk_cf = 2'h0;
   logic [VCI_W-1:0] i_vci, i_rx_chk_vci = 20'h0, o_sel_vci, o_ep_tx_vci, o_ep_rx_vci, v0, v1;
   logic [MAP_W-1:0] i_map, i_sel_map = 16'h0, m0, m1;
   logic [EP_W-1:0] i_endpoint_identifier, i_ep_query = 2'h0, epn = 2'h0;
   logic [PAIRS*VCI_W-1:0] i_tx_vcis = '0, i_rx_vcis = '0;
   logic [PAIRS*OFS_W-1:0] i_tx_ofs = '0, i_rx_ofs = '0;
   logic [PAIRS-1:0] i_tx_used = 4'h0, i_rx_used = 4'h0;
   logic [REASON_W-1:0] o_reply_reason;
   logic [PRIO_W-1:0] i_sel_prio = 2'h0;
   logic [MID_W-1:0] i_seq_mid = 2'h0;
   logic [PAIR_W-1:0] i_pair_query = 2'h0;
   logic [SEQ_W-1:0] o_seq;
   logic [OFS_W-1:0] o_ep_tx_ofs, o_ep_rx_ofs;
   int err_total = 0, compares = 0, seed = 76666, cyc = 0;

   mgmt_process_model u_mgmt_process_model (.i_core_clk, .i_reply_valid(o_reply_valid),
      .o_cmd_valid(i_cmd_valid), .o_cmd(i_cmd), .o_cf_type(i_cf_type), .o_vci(i_vci),
      .o_dir(i_dir), .o_map(i_map), .o_endpoint_identifier(i_endpoint_identifier));
   channel_id_table_manager u_channel_id_table_manager (.i_core_clk, .i_rst_n, .i_cmd_valid,
      .i_cmd, .i_cf_type, .i_vci, .i_dir, .i_map, .i_endpoint_identifier, .i_tx_bus,
      .i_rx_bus, .i_tx_vcis, .i_tx_ofs, .i_tx_used, .i_rx_vcis, .i_rx_ofs, .i_rx_used,
      .o_reply_valid, .o_reply_ok, .o_reply_reason, .i_sel_cf, .i_sel_map, .i_sel_prio,
      .o_sel_hit, .o_sel_vci, .o_sel_bus_a, .o_sel_bus_b, .i_rx_chk_vci, .i_rx_chk_cf,
      .o_rx_accept, .i_seq_step, .i_seq_mid, .o_seq, .i_ep_query, .i_pair_query,
      .o_ep_active, .o_ep_tx_bus_b, .o_ep_rx_bus_b, .o_ep_tx_vci, .o_ep_tx_ofs,
      .o_ep_tx_pair_used, .o_ep_rx_vci, .o_ep_rx_ofs, .o_ep_rx_pair_used);

   initial begin
      forever #10 i_core_clk = ~i_core_clk;
   end

   task automatic print_verdict();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   always @(posedge i_core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         $display("CHECK FAILED at %0t: run hung", $time);
         print_verdict();
      end
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: got %0h want %0h", $time, got, exp);
      end
   endtask

   task automatic act(input cmd_t c, input logic [CF_W-1:0] f, input logic [VCI_W-1:0] v,
         input dir_t d, input logic [MAP_W-1:0] m, input logic ok, input logic [2:0] r);
      u_mgmt_process_model.issue(c, f, v, d, m, epn, seen);
      chk({seen, o_reply_ok, o_reply_reason}, {1'b1, ok, r});
   endtask

   task automatic look(input logic [1:0] f, input logic [15:0] m, input logic [1:0] p,
         input logic h, input logic [VCI_W-1:0] v);
      @(negedge i_core_clk);
      i_sel_cf = f;
      i_sel_map = m;
      i_sel_prio = p;
      @(negedge i_core_clk);
      chk({o_sel_hit, o_sel_bus_a, o_sel_bus_b}, {h, h, h});
      if (h) chk(o_sel_vci, v);
   endtask

   task automatic rxq(input logic [VCI_W-1:0] v, input logic [1:0] f, input logic a);
      @(negedge i_core_clk);
      i_rx_chk_vci = v;
      i_rx_chk_cf = f;
      @(negedge i_core_clk);
      chk(o_rx_accept, a);
   endtask

   task automatic seqchk(input int k, input int n);
      i_seq_mid = MID_W'(k);
      repeat (2) @(negedge i_core_clk);
      chk(o_seq, n);
   endtask

   task automatic epchk(input logic [1:0] e, input logic [1:0] p, input logic a);
      @(negedge i_core_clk);
      i_ep_query = e;
      i_pair_query = p;
      @(negedge i_core_clk);
      chk(o_ep_active, a);
      if (a && e == epn) begin
         chk({o_ep_tx_bus_b, o_ep_rx_bus_b, o_ep_tx_pair_used, o_ep_rx_pair_used},
            {i_tx_bus, i_rx_bus, i_tx_used[p], i_rx_used[p]});
         chk({o_ep_tx_ofs, o_ep_rx_ofs, o_ep_tx_vci, o_ep_rx_vci},
            {i_tx_ofs[p*OFS_W+:OFS_W], i_rx_ofs[p*OFS_W+:OFS_W],
             i_tx_vcis[p*VCI_W+:VCI_W], i_rx_vcis[p*VCI_W+:VCI_W]});
      end
   endtask

   task automatic rnd_pairs();
      for (int p = 0; p < PAIRS; p++) begin
         i_tx_vcis[p*VCI_W+:VCI_W] = VCI_W'($random(seed));
         i_rx_vcis[p*VCI_W+:VCI_W] = VCI_W'($random(seed));
         i_tx_ofs[p*OFS_W+:OFS_W] = OFS_W'(1 + $unsigned($random(seed)) % 48);
         i_rx_ofs[p*OFS_W+:OFS_W] = OFS_W'(1 + $unsigned($random(seed)) % 48);
      end
      i_tx_used = PAIRS'($random(seed));
      i_rx_used = PAIRS'($random(seed));
      i_tx_bus = ($random(seed) & 1) ? BUS_SEL_B : BUS_SEL_A;
      i_rx_bus = ($random(seed) & 1) ? BUS_SEL_B : BUS_SEL_A;
   endtask

   initial begin
      v0 = VCI_W'($random(seed));
      v1 = v0 + 20'h100;
      m0 = MAP_W'($random(seed));
      m1 = ~m0;
      repeat (6) @(negedge i_core_clk);
      chk(o_reply_valid, 1'b0);
      i_rst_n = 1'b1;
      act(CMD_CHANNEL_ADD, CF_MAC, v0, DIR_TRANSMIT, m0, 1'b1, RSN_NONE);
      look(CF_MAC, m0, PRIO_W'($unsigned($random(seed)) % 3), 1'b1, v0);
      look(CF_MAC, m0, 2'h3, 1'b0, v0);
      look(CF_MAC, m1, 2'h0, 1'b0, v0);
      rxq(v0, CF_MAC, 1'b0);
      act(CMD_CHANNEL_ADD, CF_MAC, v0, DIR_RECEIVE, m1, 1'b1, RSN_NONE);
      rxq(v0, CF_MAC, 1'b1);
      rxq(v0, 2'h1, 1'b0);
      act(CMD_CHANNEL_ADD, 2'h1, v0, DIR_TRANSMIT, m1, 1'b0, RSN_REBIND);
      act(CMD_CHANNEL_ADD, CF_MAC, v1, DIR_TRANSMIT, m0, 1'b0, RSN_MAP_CLASH);
      for (int k = 0; k < 7; k++) begin
         act(CMD_CHANNEL_ADD, CF_MAC, v1 + VCI_W'(k), DIR_RECEIVE, m0, k < 6,
            (k < 6) ? RSN_NONE : RSN_FULL);
         rxq(v1 + VCI_W'(k), CF_MAC, k < 6);
      end
      look(CF_MAC, m0, 2'h0, 1'b1, v0);
      for (int k = 0; k < 4; k++) begin
         i_seq_mid = MID_W'(k);
         repeat (k + 1) @(negedge i_core_clk) i_seq_step = 1'b1;
         @(negedge i_core_clk) i_seq_step = 1'b0;
      end
      for (int k = 0; k < 4; k++) seqchk(k, k + 1);
      $display("channel add test done");
      act(CMD_CHANNEL_REMOVE, CF_MAC, v0, DIR_TRANSMIT, m0, 1'b1, RSN_NONE);
      look(CF_MAC, m0, 2'h0, 1'b0, v0);
      rxq(v0, CF_MAC, 1'b1);
      act(CMD_CHANNEL_REMOVE, CF_MAC, v0, DIR_TRANSMIT, m0, 1'b0, RSN_NOT_FOUND);
      act(CMD_CHANNEL_ADD, CF_MAC, v0, DIR_TRANSMIT, m1, 1'b1, RSN_NONE);
      look(CF_MAC, m0, 2'h0, 1'b0, v0);
      look(CF_MAC, m1, 2'h1, 1'b1, v0);
      for (int k = 0; k < 4; k++) seqchk(k, 0);
      act(CMD_OTHER, CF_MAC, v0, DIR_TRANSMIT, m0, 1'b0, RSN_BAD_CMD);
      $display("channel remove test done");
      epn = 2'h2;
      for (int b = 0; b < 2; b++) begin
         rnd_pairs();
         i_tx_ofs[OFS_W+:OFS_W] = b ? 6'h31 : 6'h00;
         i_tx_used[1] = 1'b1;
         act(CMD_ENDPOINT_OPEN, CF_MAC, v0, DIR_TRANSMIT, m0, 1'b0, RSN_BAD_OFFSET);
         epchk(2'h2, 2'h1, 1'b0);
      end
      for (int k = 0; k < 4; k++) begin
         rnd_pairs();
         i_rx_ofs[2*OFS_W-1:0] = {6'h30, 6'h01};
         i_rx_used[1:0] = 2'h3;
         epn = EP_W'(k);
         act(CMD_ENDPOINT_OPEN, CF_MAC, v0, DIR_TRANSMIT, m0, 1'b1, RSN_NONE);
         for (int p = 0; p < 4; p++) epchk(EP_W'(k), PAIR_W'(p), 1'b1);
      end
      for (int k = 0; k < 4; k++) epchk(EP_W'(k), 2'h0, 1'b1);
      $display("endpoint open test done");
      print_verdict();
   end
endmodule
